// ### src/bpws_pkg.sv
/*
  Shared types and constants of the branch prediction window store.
  Assumes a 32-bit fetch address space and one core clock.
*/
package bpws_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned OFF_W = 4;
  localparam int unsigned SLOTS = 3;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned DEPTH = 64;
  localparam int unsigned TAG_W = ADDR_W - OFF_W - IDX_W;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned RAS_DEPTH = 8;
  localparam int unsigned RAS_PTR_W = 3;
  localparam int unsigned RAS_CNT_W = 4;

  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam logic [RAS_CNT_W-1:0] RAS_FULL = 4'h8;
  localparam logic [RAS_PTR_W-1:0] RAS_PTR_RST = 3'h0;
  localparam logic [1:0] VICTIM_RST = 2'h0;
  localparam logic [1:0] VICTIM_LAST = 2'h2;
  localparam logic [ADDR_W-1:0] ONE_BYTE = 32'h1;
  localparam logic [IMM_W-1:0] IMM_ZERO = 16'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BPWS_COND, BPWS_JMP, BPWS_CALL, BPWS_RET_SHORT, BPWS_RET_IMM, BPWS_FAR
  } bpws_kind_e;

  typedef enum logic {BPWS_IDLE, BPWS_UPD} bpws_phase_e;

  typedef struct packed {
    logic [SLOTS-1:0] valid;
    logic [SLOTS-1:0][OFF_W-1:0] end_off;
    logic [SLOTS-1:0][ADDR_W-1:0] target;
    logic [SLOTS-1:0] split;
    logic [SLOTS-1:0] is_ret;
    logic [1:0] victim;
    logic [TAG_W-1:0] tag;
  } bpws_entry_s;

endpackage

// ### src/bpws_mem.sv
/*
  Window entry memory: one write port, one read port with registered data.
  Assumes the caller never reads and writes the same entry in one cycle.
*/
`timescale 1ns/100ps
module bpws_mem (
  input wire logic clk,
  input wire logic reset,
  input wire logic rd_en,
  input wire logic [bpws_pkg::IDX_W-1:0] rd_addr,
  output bpws_pkg::bpws_entry_s rd_data,
  input wire logic wr_en,
  input wire logic [bpws_pkg::IDX_W-1:0] wr_addr,
  input bpws_pkg::bpws_entry_s wr_data
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  bpws_pkg::bpws_entry_s mem_r [bpws_pkg::DEPTH];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < bpws_pkg::DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data <= mem_r[rd_addr];
      end
    end
  end

endmodule

// ### src/bpws_store.sv
/*
  Branch prediction window store with return address stack.
  Assumes fetch and resolve requests synchronous to clk; resolves arrive
  with the branch start address, length and kind.
*/
`timescale 1ns/100ps
module bpws_store (
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_valid,
  output logic fetch_ready,
  input wire logic [31:0] fetch_instruction_pointer,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [31:0] res_instruction_pointer,
  input wire logic [3:0] res_length,
  input bpws_pkg::bpws_kind_e res_kind,
  input wire logic res_taken,
  input wire logic [31:0] res_target,
  input wire logic [15:0] res_stack_adjust_immediate,
  input wire logic res_zero_displacement,
  input wire logic res_is_branch_target,
  input wire logic res_after_conditional,
  output logic pred_done,
  output logic pred_valid,
  output logic [3:0] pred_end_offset,
  output logic [31:0] pred_target,
  output logic pred_split,
  output logic pred_is_return,
  output logic dispatch_solo
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    bpws_pkg::bpws_phase_e phase;
    logic look_pend;
    logic [bpws_pkg::OFF_W-1:0] look_off;
    logic [bpws_pkg::TAG_W-1:0] look_tag;
    logic [bpws_pkg::IDX_W-1:0] upd_idx;
    logic [bpws_pkg::TAG_W-1:0] upd_tag;
    logic [bpws_pkg::OFF_W-1:0] upd_off;
    logic [31:0] upd_target;
    logic upd_split;
    logic upd_ret;
    logic done;
    logic valid;
    logic [bpws_pkg::OFF_W-1:0] end_off;
    logic [31:0] target;
    logic split;
    logic is_ret;
    logic [bpws_pkg::RAS_DEPTH-1:0][31:0] ras;
    logic [bpws_pkg::RAS_PTR_W-1:0] ras_top;
    logic [bpws_pkg::RAS_CNT_W-1:0] ras_cnt;
  } bpws_state_s;

  bpws_state_s s_r;
  bpws_state_s s_nxt;
  bpws_pkg::bpws_entry_s rd_data;
  bpws_pkg::bpws_entry_s wr_data;
  logic mem_we;
  logic mem_re;
  logic [bpws_pkg::IDX_W-1:0] rd_addr;
  logic [31:0] last_ip;
  logic res_split;
  logic res_alloc;
  logic res_push;
  logic fetch_acc;
  logic res_acc;

  // ------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------
  assign res_ready = (s_r.phase == bpws_pkg::BPWS_IDLE);
  assign fetch_ready = (s_r.phase == bpws_pkg::BPWS_IDLE) && !res_valid;
  assign fetch_acc = fetch_valid && fetch_ready;
  assign res_acc = res_valid && res_ready;

  assign last_ip = res_instruction_pointer + {28'h0, res_length} -
                   bpws_pkg::ONE_BYTE;
  assign res_split = res_instruction_pointer[31:4] != last_ip[31:4];

  assign res_alloc = res_taken && (res_kind != bpws_pkg::BPWS_FAR) &&
                     !(res_kind == bpws_pkg::BPWS_RET_SHORT &&
                       (res_is_branch_target || res_after_conditional));

  assign res_push = (res_kind == bpws_pkg::BPWS_CALL) &&
                    !res_zero_displacement;

  assign mem_re = fetch_acc || (res_acc && res_alloc);
  assign rd_addr = res_acc ? last_ip[9:4] : fetch_instruction_pointer[9:4];
  assign mem_we = (s_r.phase == bpws_pkg::BPWS_UPD);

  bpws_mem u_mem (
    .clk(clk),
    .reset(reset),
    .rd_en(mem_re),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(mem_we),
    .wr_addr(s_r.upd_idx),
    .wr_data(wr_data)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic hit;
    logic found;
    logic [1:0] slot;
    logic [bpws_pkg::OFF_W-1:0] best;
    bpws_pkg::bpws_entry_s e;
    hit = 1'b0;
    found = 1'b0;
    slot = 2'h0;
    best = '1;
    e = rd_data;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.look_pend = fetch_acc;
    if (fetch_acc) begin
      s_nxt.look_off = fetch_instruction_pointer[3:0];
      s_nxt.look_tag = fetch_instruction_pointer[31:10];
    end
    // Lookup answer: nearest stored branch ending at or after fetch offset
    if (s_r.look_pend) begin
      s_nxt.done = 1'b1;
      s_nxt.valid = 1'b0;
      s_nxt.end_off = '0;
      s_nxt.target = '0;
      s_nxt.split = 1'b0;
      s_nxt.is_ret = 1'b0;
      for (int i = 0; i < bpws_pkg::SLOTS; i++) begin
        if (rd_data.tag == s_r.look_tag && rd_data.valid[i] &&
            rd_data.end_off[i] >= s_r.look_off &&
            (!hit || rd_data.end_off[i] < best)) begin
          hit = 1'b1;
          best = rd_data.end_off[i];
          slot = 2'(i);
        end
      end
      if (hit) begin
        s_nxt.valid = 1'b1;
        s_nxt.end_off = best;
        s_nxt.split = rd_data.split[slot];
        s_nxt.is_ret = rd_data.is_ret[slot];
        s_nxt.target = rd_data.target[slot];
        if (rd_data.is_ret[slot] && s_r.ras_cnt != '0) begin
          s_nxt.target = s_r.ras[s_r.ras_top];
          s_nxt.ras_top = s_r.ras_top - 3'h1;
          s_nxt.ras_cnt = s_r.ras_cnt - 4'h1;
        end
      end
    end
    if (res_acc && res_push) begin
      s_nxt.ras_top = s_nxt.ras_top + 3'h1;
      s_nxt.ras[s_nxt.ras_top] = last_ip + bpws_pkg::ONE_BYTE;
      if (s_nxt.ras_cnt != bpws_pkg::RAS_FULL) begin
        s_nxt.ras_cnt = s_nxt.ras_cnt + 4'h1;
      end
    end
    if (res_acc && res_alloc) begin
      s_nxt.phase = bpws_pkg::BPWS_UPD;
      s_nxt.upd_idx = last_ip[9:4];
      s_nxt.upd_tag = last_ip[31:10];
      s_nxt.upd_off = last_ip[3:0];
      s_nxt.upd_target = res_target;
      s_nxt.upd_split = res_split;
      s_nxt.upd_ret = (res_kind == bpws_pkg::BPWS_RET_SHORT) ||
                      (res_kind == bpws_pkg::BPWS_RET_IMM);
    end
    if (e.tag != s_r.upd_tag) begin
      e = '0;
      e.tag = s_r.upd_tag;
    end
    slot = e.victim;
    for (int i = bpws_pkg::SLOTS - 1; i >= 0; i--) begin
      if (!e.valid[i] && !found) begin
        slot = 2'(i);
      end
      if (e.valid[i] && e.end_off[i] == s_r.upd_off) begin
        found = 1'b1;
        slot = 2'(i);
      end
    end
    if (!found && (&e.valid)) begin
      e.victim = (e.victim == bpws_pkg::VICTIM_LAST) ?
                 bpws_pkg::VICTIM_RST : e.victim + 2'h1;
    end
    e.valid[slot] = 1'b1;
    e.end_off[slot] = s_r.upd_off;
    e.target[slot] = s_r.upd_target;
    e.split[slot] = s_r.upd_split;
    e.is_ret[slot] = s_r.upd_ret;
    wr_data = e;
    if (mem_we) begin
      s_nxt.phase = bpws_pkg::BPWS_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.phase <= bpws_pkg::BPWS_IDLE;
      s_r.ras_top <= bpws_pkg::RAS_PTR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pred_done = s_r.done;
  assign pred_valid = s_r.valid && s_r.done;
  assign pred_end_offset = s_r.end_off;
  assign pred_target = s_r.target;
  assign pred_split = s_r.split;
  assign pred_is_return = s_r.is_ret;
  assign dispatch_solo = pred_valid && s_r.split;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fetch_acc;
    fetch_valid && fetch_ready;
  endsequence

  sequence s_res_store;
    res_valid && res_ready && res_alloc;
  endsequence

  a_lookup_latency: assert property (
    s_fetch_acc |-> ##1 s_r.look_pend ##1 pred_done)
    else $error("lookup answer not two cycles after fetch");

  a_taken_only: assert property (
    mem_we |-> $past(res_valid && res_ready && res_taken))
    else $error("entry written for branch never taken");

  a_far_never: assert property (
    res_valid && res_ready && res_kind == bpws_pkg::BPWS_FAR |=> !mem_we)
    else $error("far transfer entered in store");

  a_last_byte_win: assert property (
    s_res_store |=> mem_we && s_r.upd_idx == $past(last_ip[9:4]) &&
      s_r.upd_off == $past(last_ip[3:0]))
    else $error("branch not placed by its last byte");

  a_split_solo: assert property (
    pred_done && pred_valid && pred_split |->
      dispatch_solo ##1 (!dispatch_solo || pred_done))
    else $error("split taken branch not dispatched alone");

  a_slot_unique: assert property (
    mem_we |-> !(wr_data.valid[0] && wr_data.valid[1] &&
      wr_data.end_off[0] == wr_data.end_off[1]) &&
      !(wr_data.valid[1] && wr_data.valid[2] &&
      wr_data.end_off[1] == wr_data.end_off[2]) &&
      !(wr_data.valid[0] && wr_data.valid[2] &&
      wr_data.end_off[0] == wr_data.end_off[2]))
    else $error("two slots hold the same branch");

  a_evict_round: assert property (
    mem_we && (&rd_data.valid) && rd_data.tag == s_r.upd_tag &&
      wr_data.victim != rd_data.victim |->
      wr_data.end_off[rd_data.victim] == s_r.upd_off)
    else $error("conflict did not replace the victim slot");

  a_ras_push: assert property (
    res_valid && res_ready && res_push && !s_r.look_pend |=>
      s_r.ras_top == $past(s_r.ras_top) + 3'h1 &&
      s_r.ras[s_r.ras_top] == $past(last_ip) + bpws_pkg::ONE_BYTE)
    else $error("call did not push next address");

  a_zero_call: assert property (
    res_valid && res_ready && res_kind == bpws_pkg::BPWS_CALL &&
      res_zero_displacement && !s_r.look_pend |=> $stable(s_r.ras_top))
    else $error("zero displacement call moved the stack");

  a_ret_eligible: assert property (
    res_valid && res_ready && res_taken &&
      res_kind == bpws_pkg::BPWS_RET_IMM &&
      res_stack_adjust_immediate == bpws_pkg::IMM_ZERO |=> mem_we && s_r.upd_ret)
    else $error("zero immediate return not entered");

endmodule

// ### testbench/bpws_front.sv
/*
  Fetch and resolve stage model that drives the window store.
  Assumes tasks are started from a clocked caller.
*/
`timescale 1ns/100ps
module bpws_front (
  input wire logic clk,
  input wire logic fetch_ready,
  input wire logic res_ready,
  input wire logic pred_done,
  input wire logic pred_valid,
  input wire logic dispatch_solo,
  output logic fetch_valid,
  output logic [31:0] fetch_instruction_pointer,
  output logic res_valid,
  output logic [31:0] res_instruction_pointer,
  output logic [3:0] res_length,
  output bpws_pkg::bpws_kind_e res_kind,
  output logic res_taken,
  output logic [31:0] res_target,
  output logic [15:0] res_stack_adjust_immediate,
  output logic res_zero_displacement,
  output logic res_is_branch_target,
  output logic res_after_conditional
);
  // ----------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------
  initial begin
    {fetch_valid, res_valid, res_taken} = 3'h0;
    fetch_instruction_pointer = 32'h0;
    {res_instruction_pointer, res_target} = 64'h0;
    res_length = 4'h1;
    res_kind = bpws_pkg::BPWS_COND;
    res_stack_adjust_immediate = 16'h0;
    {res_zero_displacement, res_is_branch_target} = 2'h0;
    res_after_conditional = 1'h0;
  end

  // ----------------------------------------------------------
  // Lookup: hold request until accepted, catch the pulses
  // ----------------------------------------------------------
  task automatic lookup(input logic [31:0] ip, output logic h,
                        output logic s);
    int n;
    logic acc;
    n = 0;
    h = 1'bx;
    s = 1'bx;
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_instruction_pointer <= ip;
    do begin
      #1 acc = fetch_ready;
      @(posedge clk);
      n++;
    end while (!acc && n < 8);
    fetch_valid <= 1'b0;
    fetch_instruction_pointer <= ~ip;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (pred_done === 1'b1) begin
        h = pred_valid;
        s = dispatch_solo;
        break;
      end
      @(posedge clk);
    end
  endtask

  // ----------------------------------------------------------
  // Resolve: hold request until accepted
  // ----------------------------------------------------------
  task automatic resolve(input logic [31:0] ip, input logic [3:0] len,
                         input bpws_pkg::bpws_kind_e k, input logic tk,
                         input logic [31:0] tg, input logic [2:0] fl);
    int n;
    logic acc;
    n = 0;
    @(posedge clk);
    res_valid <= 1'b1;
    res_instruction_pointer <= ip;
    res_length <= len;
    res_kind <= k;
    res_taken <= tk;
    res_target <= tg;
    res_stack_adjust_immediate <= 16'h0;
    {res_zero_displacement, res_is_branch_target} <= fl[2:1];
    res_after_conditional <= fl[0];
    do begin
      #1 acc = res_ready;
      @(posedge clk);
      n++;
    end while (!acc && n < 8);
    res_valid <= 1'b0;
    res_instruction_pointer <= ~ip;
    res_target <= ~tg;
    res_stack_adjust_immediate <= 16'hA5A5;
  endtask
endmodule

// ### testbench/tb_branch_prediction_window_store.sv
/*
  Self-checking bench of the window store.
  Assumes the front model drives every request input.
*/
`timescale 1ns/100ps
module tb_branch_prediction_window_store;
  logic clk, reset, fetch_valid, fetch_ready, res_valid, res_ready;
  logic [31:0] fetch_instruction_pointer, res_instruction_pointer;
  logic [3:0] res_length, pred_end_offset;
  bpws_pkg::bpws_kind_e res_kind;
  logic res_taken, res_zero_displacement, res_is_branch_target;
  logic [31:0] res_target, pred_target;
  logic [15:0] res_stack_adjust_immediate;
  logic res_after_conditional, pred_done, pred_valid, pred_split;
  logic pred_is_return, dispatch_solo;
  int miscompares = 0;
  int n_checks = 0;

  bpws_store uut (.clk, .reset, .fetch_valid, .fetch_ready,
    .fetch_instruction_pointer, .res_valid, .res_ready,
    .res_instruction_pointer, .res_length, .res_kind, .res_taken,
    .res_target, .res_stack_adjust_immediate, .res_zero_displacement,
    .res_is_branch_target, .res_after_conditional, .pred_done,
    .pred_valid, .pred_end_offset, .pred_target, .pred_split,
    .pred_is_return, .dispatch_solo);

  bpws_front fe (.clk, .fetch_ready, .res_ready, .pred_done, .pred_valid,
    .dispatch_solo, .fetch_valid, .fetch_instruction_pointer, .res_valid,
    .res_instruction_pointer, .res_length, .res_kind, .res_taken,
    .res_target, .res_stack_adjust_immediate, .res_zero_displacement,
    .res_is_branch_target, .res_after_conditional);

  // ----------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic probe(input logic [31:0] ip, input logic hit,
                       input logic [3:0] off, input logic [31:0] tg,
                       input logic sp, input logic rt);
    logic h, s;
    fe.lookup(ip, h, s);
    chk("pred_valid", {31'h0, hit}, {31'h0, h});
    if (hit) begin
      chk("pred_end_offset", {28'h0, off}, {28'h0, pred_end_offset});
      chk("pred_target", tg, pred_target);
      chk("pred_split", {31'h0, sp}, {31'h0, pred_split});
      chk("dispatch_solo", {31'h0, sp}, {31'h0, s});
      chk("pred_is_return", {31'h0, rt}, {31'h0, pred_is_return});
    end
  endtask

  task automatic results;
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_basic;
    fe.resolve(32'h1004, 4'h2, bpws_pkg::BPWS_COND, 1'b1, 32'h2000, 3'h0);
    #1;
    chk("res_ready", 32'h0, {31'h0, res_ready});
    chk("fetch_ready", 32'h0, {31'h0, fetch_ready});
    probe(32'h1000, 1'b1, 4'h5, 32'h2000, 1'b0, 1'b0);
    probe(32'h1006, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
    fe.resolve(32'h1024, 4'h2, bpws_pkg::BPWS_COND, 1'b0, 32'h2010, 3'h0);
    #1;
    chk("res_ready", 32'h1, {31'h0, res_ready});
    chk("fetch_ready", 32'h1, {31'h0, fetch_ready});
    probe(32'h1020, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
  endtask

  task automatic t_split;
    fe.resolve(32'h103E, 4'h4, bpws_pkg::BPWS_JMP, 1'b1, 32'h2100, 3'h0);
    probe(32'h1040, 1'b1, 4'h1, 32'h2100, 1'b1, 1'b0);
    probe(32'h1030, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
  endtask

  task automatic t_slots;
    for (int i = 0; i < 4; i++) begin
      fe.resolve(32'h1051 + 3 * i, 4'h2, bpws_pkg::BPWS_JMP, 1'b1,
                 32'h2202 + 3 * i, 3'h0);
      if (i == 2) begin
        probe(32'h1050, 1'b1, 4'h2, 32'h2202, 1'b0, 1'b0);
        probe(32'h1056, 1'b1, 4'h8, 32'h2208, 1'b0, 1'b0);
      end
    end
    probe(32'h1050, 1'b1, 4'h5, 32'h2205, 1'b0, 1'b0);
    probe(32'h1059, 1'b1, 4'hB, 32'h220B, 1'b0, 1'b0);
  endtask

  task automatic t_returns;
    fe.resolve(32'h1070, 4'h1, bpws_pkg::BPWS_RET_SHORT, 1'b1, 32'h2300,
               3'h2);
    probe(32'h1070, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
    fe.resolve(32'h1090, 4'h1, bpws_pkg::BPWS_RET_SHORT, 1'b1, 32'h2300,
               3'h1);
    probe(32'h1090, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
    fe.resolve(32'h1080, 4'h3, bpws_pkg::BPWS_RET_IMM, 1'b1, 32'h2400,
               3'h0);
    fe.resolve(32'h1060, 4'h5, bpws_pkg::BPWS_CALL, 1'b1, 32'h2500, 3'h0);
    probe(32'h1080, 1'b1, 4'h2, 32'h1065, 1'b0, 1'b1);
    probe(32'h1080, 1'b1, 4'h2, 32'h2400, 1'b0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      fe.resolve(32'h1100 + 32'h10 * i, 4'h5, bpws_pkg::BPWS_CALL, 1'b0,
                 32'h2600, 3'h0);
    end
    for (int i = 8; i > 0; i--) begin
      probe(32'h1080, 1'b1, 4'h2, 32'h1105 + 32'h10 * i, 1'b0, 1'b1);
    end
    probe(32'h1080, 1'b1, 4'h2, 32'h2400, 1'b0, 1'b1);
    fe.resolve(32'h10B0, 4'h5, bpws_pkg::BPWS_CALL, 1'b0, 32'h10B5, 3'h4);
    probe(32'h1080, 1'b1, 4'h2, 32'h2400, 1'b0, 1'b1);
  endtask

  task automatic t_far;
    fe.resolve(32'h10C4, 4'h7, bpws_pkg::BPWS_FAR, 1'b1, 32'h2700, 3'h0);
    probe(32'h10C0, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
  endtask

  // ----------------------------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_basic;
    t_split;
    t_slots;
    t_returns;
    t_far;
    results;
  end

  initial begin
    #200000;
    miscompares++;
    results;
  end
endmodule
